// *** stm_params.svh ***
// Register offsets, field positions and reset values of the standard timer
`ifndef STM_PARAMS_SVH
`define STM_PARAMS_SVH
`define STM_OFS_CTRL0      4'h0
`define STM_OFS_CTRL1      4'h1
`define STM_OFS_CNT_LO     4'h2
`define STM_OFS_CNT_HI     4'h3
`define STM_OFS_CMPA_LO    4'h4
`define STM_OFS_CMPA_HI    4'h5
`define STM_OFS_PERIOD     4'h6
`define STM_BIT_PAUSE      7
`define STM_BIT_ON         3
`define STM_CKS_HI         6
`define STM_CKS_LO         4
`define STM_MODE_HI        7
`define STM_MODE_LO        6
`define STM_FUNC_HI        5
`define STM_FUNC_LO        4
`define STM_BIT_LEVEL      3
`define STM_BIT_INV        2
`define STM_BIT_SWAP       1
`define STM_BIT_CLRSEL     0
`define STM_CTRL0_MASK     8'hf8
`define STM_RST_BYTE       8'h00
`define STM_DIV_SYS4       8'h03
`define STM_DIV_H16        8'h0f
`define STM_DIV_H64        8'h3f
`endif

// *** stm_pkg.sv ***
// Types shared by the standard timer
package stm_pkg;
  typedef enum logic [1:0] {
    STM_MODE_COMPARE = 2'h0,
    STM_MODE_CAPTURE = 2'h1,
    STM_MODE_PWM     = 2'h2,
    STM_MODE_TIMER   = 2'h3
  } stm_mode_t;

  // Decoded control fields
  typedef struct packed {
    logic       count_pause;
    logic [2:0] count_clock_select;
    logic       timer_on;
    stm_mode_t  operating_mode_select;
    logic [1:0] output_function_select;
    logic       output_level_control;
    logic       output_invert;
    logic       period_duty_swap;
    logic       clear_source_select;
  } stm_ctrl_t;

  // Bus transfer answer
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } stm_rdata_t;
endpackage

// *** stm_timer.sv ***
// Standard 16-bit timer with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
`include "stm_params.svh"

module stm_timer
  import stm_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input  wire logic              I_CLK,
  input  wire logic              I_RST_N,
  input  wire logic [ADDR_W-1:0] I_AVS_ADDRESS,
  input  wire logic              I_AVS_READ,
  input  wire logic              I_AVS_WRITE,
  input  wire logic [31:0]       I_AVS_WRITEDATA,
  output var  logic [31:0]       O_AVS_READDATA,
  output logic                   O_AVS_WAITREQUEST,
  input  wire logic              I_EXTERNAL_COUNT_INPUT,
  input  wire logic              I_CAPTURE_INPUT,
  input  wire logic              I_INTERNAL_HIGH_CLOCK_TICK,
  input  wire logic              I_TIME_BASE_CLOCK_TICK,
  input  wire logic              I_SECOND_COMPLEMENT,
  output logic                   O_TIMER_OUTPUT_FIRST,
  output logic                   O_TIMER_OUTPUT_SECOND,
  output logic                   O_TIMER_OUTPUT_OE,
  output logic                   O_COMPARE_A_MATCH_FLAG,
  output logic                   O_COMPARE_P_MATCH_FLAG
);

  // Offsets 0 to 6 need at least three address bits
  if (ADDR_W < 3) begin : g_addr_check
    $error("ADDR_W too small for register map");
  end

  //--------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------
  // Software-visible state and internal flops
  logic [7:0]  ctrl0_ff;
  logic [7:0]  ctrl1_ff;
  logic [15:0] cnt_ff;
  logic [15:0] cmpa_ff;
  logic [7:0]  period_ff;
  logic [7:0]  wbuf_ff;
  logic [7:0]  rbuf_ff;
  logic        on_d_ff;
  logic        out_ff;
  logic        pulse_done_ff;
  logic [7:0]  div_ff;
  logic [7:0]  nxt_div;
  logic [1:0]  ext_sync_ff;
  logic        ext_d_ff;
  logic [1:0]  cap_sync_ff;
  logic        cap_d_ff;
  logic        ack_ff;
  logic [7:0]  rdata_ff;
  logic [1:0]  tick_sync_ff;
  logic        tick_h_ff;
  logic        tick_t_ff;
  logic        match_a_ff;
  logic        match_p_ff;

  // Decoded fields and combinational terms
  stm_ctrl_t   ctl;
  logic        on_rise;
  logic        tick;
  logic        run;
  logic        match_a;
  logic        match_p;
  logic        ovf;
  logic        clr;
  logic [15:0] nxt_cnt;
  logic        wr_go;
  logic        rd_go;
  logic [16:0] pwm_period;
  logic [16:0] pwm_duty;
  logic        pwm_act;
  logic        pwm_wave;
  logic        base_out;
  logic        cap_edge;

  // Control fields gathered into one struct
  assign ctl = {ctrl0_ff[`STM_BIT_PAUSE], ctrl0_ff[`STM_CKS_HI:`STM_CKS_LO], ctrl0_ff[`STM_BIT_ON],
                stm_mode_t'(ctrl1_ff[`STM_MODE_HI:`STM_MODE_LO]), ctrl1_ff[`STM_FUNC_HI:`STM_FUNC_LO],
                ctrl1_ff[`STM_BIT_LEVEL], ctrl1_ff[`STM_BIT_INV], ctrl1_ff[`STM_BIT_SWAP],
                ctrl1_ff[`STM_BIT_CLRSEL]};

  //--------------------------------------------------------------
  // Bus slave: one wait cycle, answer on the next edge
  //--------------------------------------------------------------
  assign O_AVS_WAITREQUEST = (I_AVS_READ | I_AVS_WRITE) & ~ack_ff;
  assign wr_go = I_AVS_WRITE & ack_ff;
  // Reads sample in the wait cycle, so data stands when waitrequest drops
  assign rd_go = I_AVS_READ & ~ack_ff;
  assign O_AVS_READDATA = {24'h000000, rdata_ff};

  // Acknowledge toggles for each request
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) ack_ff <= 1'b0;
    else          ack_ff <= (I_AVS_READ | I_AVS_WRITE) & ~ack_ff;
  end

  // Read data mux, registered in the wait cycle
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      rdata_ff <= `STM_RST_BYTE;
    end else if (rd_go) begin
      case (I_AVS_ADDRESS)
        `STM_OFS_CTRL0:   rdata_ff <= ctrl0_ff & `STM_CTRL0_MASK;
        `STM_OFS_CTRL1:   rdata_ff <= ctrl1_ff;
        `STM_OFS_CNT_LO:  rdata_ff <= rbuf_ff;
        `STM_OFS_CNT_HI:  rdata_ff <= cnt_ff[15:8];
        `STM_OFS_CMPA_LO: rdata_ff <= rbuf_ff;
        `STM_OFS_CMPA_HI: rdata_ff <= cmpa_ff[15:8];
        `STM_OFS_PERIOD:  rdata_ff <= period_ff;
        default:          rdata_ff <= `STM_RST_BYTE;
      endcase
    end
  end

  // High-byte read captures the low byte into the buffer, on the
  // same edge that samples the high byte, so a carry from the low
  // byte can never split the pair between the two reads
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      rbuf_ff <= `STM_RST_BYTE;
    end else if (rd_go && I_AVS_ADDRESS == `STM_OFS_CNT_HI) begin
      rbuf_ff <= cnt_ff[7:0];
    end else if (rd_go && I_AVS_ADDRESS == `STM_OFS_CMPA_HI) begin
      rbuf_ff <= cmpa_ff[7:0];
    end
  end

  // Control and compare registers
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      ctrl0_ff  <= `STM_RST_BYTE;
      ctrl1_ff  <= `STM_RST_BYTE;
      cmpa_ff   <= {`STM_RST_BYTE, `STM_RST_BYTE};
      period_ff <= `STM_RST_BYTE;
      wbuf_ff   <= `STM_RST_BYTE;
    end else if (wr_go) begin
      case (I_AVS_ADDRESS)
        `STM_OFS_CTRL0:   ctrl0_ff  <= I_AVS_WRITEDATA[7:0] & `STM_CTRL0_MASK;
        `STM_OFS_CTRL1:   ctrl1_ff  <= I_AVS_WRITEDATA[7:0];
        `STM_OFS_CMPA_LO: wbuf_ff   <= I_AVS_WRITEDATA[7:0];
        `STM_OFS_CMPA_HI: cmpa_ff   <= {I_AVS_WRITEDATA[7:0], wbuf_ff};
        `STM_OFS_PERIOD:  period_ff <= I_AVS_WRITEDATA[7:0];
        default:          ;
      endcase
    end
  end

  //--------------------------------------------------------------
  // Input synchronisers and edge detection
  //--------------------------------------------------------------
  // Two flops per pin before any logic reads it, then one delay flop
  // Time-base tick is a same-domain pulse, only retimed once
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      ext_sync_ff  <= 2'h0;
      ext_d_ff     <= 1'b0;
      cap_sync_ff  <= 2'h0;
      cap_d_ff     <= 1'b0;
      tick_sync_ff <= 2'h0;
      tick_h_ff    <= 1'b0;
      tick_t_ff    <= 1'b0;
    end else begin
      ext_sync_ff  <= {ext_sync_ff[0], I_EXTERNAL_COUNT_INPUT};
      ext_d_ff     <= ext_sync_ff[1];
      cap_sync_ff  <= {cap_sync_ff[0], I_CAPTURE_INPUT};
      cap_d_ff     <= cap_sync_ff[1];
      tick_sync_ff <= {tick_sync_ff[0], I_INTERNAL_HIGH_CLOCK_TICK};
      tick_h_ff    <= tick_sync_ff[1];
      tick_t_ff    <= I_TIME_BASE_CLOCK_TICK;
    end
  end

  // Capture input edge selection
  always_comb begin
    case (ctl.output_function_select)
      2'h0:    cap_edge = cap_sync_ff[1] & ~cap_d_ff;
      2'h1:    cap_edge = ~cap_sync_ff[1] & cap_d_ff;
      2'h2:    cap_edge = cap_sync_ff[1] ^ cap_d_ff;
      default: cap_edge = 1'b0;
    endcase
  end

  //--------------------------------------------------------------
  // Clock selection and prescaler
  //--------------------------------------------------------------
  // Tick source; prescaler counts system or synced high-clock cycles
  always_comb begin
    nxt_div = div_ff;
    tick    = 1'b0;
    case (ctl.count_clock_select)
      3'h0: begin
        tick    = (div_ff == `STM_DIV_SYS4);
        nxt_div = tick ? `STM_RST_BYTE : div_ff + 8'h01;
      end
      3'h1: tick = 1'b1;
      3'h2: begin
        tick    = tick_h_ff && div_ff == `STM_DIV_H16;
        nxt_div = tick_h_ff ? (tick ? `STM_RST_BYTE : div_ff + 8'h01) : div_ff;
      end
      3'h3: begin
        tick    = tick_h_ff && div_ff == `STM_DIV_H64;
        nxt_div = tick_h_ff ? (tick ? `STM_RST_BYTE : div_ff + 8'h01) : div_ff;
      end
      3'h4, 3'h5: tick = tick_t_ff;
      3'h6: tick = ext_sync_ff[1] & ~ext_d_ff;
      3'h7: tick = ~ext_sync_ff[1] & ext_d_ff;
      default: tick = 1'b0;
    endcase
  end

  // Prescaler, reset whenever the timer is off
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N || !ctl.timer_on) div_ff <= `STM_RST_BYTE;
    else                           div_ff <= nxt_div;
  end

  //--------------------------------------------------------------
  // Counter and comparators
  //--------------------------------------------------------------
  // On-edge detect, count enable and compare hits
  // Hits look at the next value, so the clear lands on the match tick
  assign on_rise = ctl.timer_on & ~on_d_ff;
  assign run     = ctl.timer_on & ~ctl.count_pause & tick;
  assign match_a = run && (cnt_ff + 16'h0001) == cmpa_ff;
  assign match_p = run && period_ff != `STM_RST_BYTE &&
                   (cnt_ff + 16'h0001) == {period_ff, `STM_RST_BYTE};
  assign ovf     = run && cnt_ff == 16'hffff;

  // Clear source choice depends on mode
  always_comb begin
    if (ctl.operating_mode_select == STM_MODE_PWM)
      clr = ctl.period_duty_swap ? match_a : (match_p | ovf);
    else if (ctl.operating_mode_select == STM_MODE_CAPTURE)
      clr = ovf;
    else if (ctl.clear_source_select)
      clr = match_a | ovf;
    else
      clr = match_p | ovf;
  end

  // Next counter value; on-edge beats clear beats count
  always_comb begin
    nxt_cnt = cnt_ff;
    if (on_rise)  nxt_cnt = 16'h0000;
    else if (clr) nxt_cnt = 16'h0000;
    else if (run) nxt_cnt = cnt_ff + 16'h0001;
  end

  // Counter and on-bit history
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      cnt_ff  <= 16'h0000;
      on_d_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      on_d_ff <= ctl.timer_on;
    end
  end

  // Match event pulses; clear-on-A hides P events in compare and timer modes
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      match_a_ff <= 1'b0;
      match_p_ff <= 1'b0;
    end else begin
      match_a_ff <= match_a | (ctl.operating_mode_select == STM_MODE_CAPTURE & ctl.timer_on & cap_edge);
      match_p_ff <= (match_p | (ovf & period_ff == `STM_RST_BYTE)) &
                    ~(ctl.clear_source_select & ctl.operating_mode_select != STM_MODE_PWM &
                      ctl.operating_mode_select != STM_MODE_CAPTURE);
    end
  end
  assign O_COMPARE_A_MATCH_FLAG = match_a_ff;
  assign O_COMPARE_P_MATCH_FLAG = match_p_ff;

  //--------------------------------------------------------------
  // PWM and output stage
  //--------------------------------------------------------------
  // Period and duty; period byte zero means 65536 counts: a full frame, or full duty when swapped
  assign pwm_period = ctl.period_duty_swap ? {1'b0, cmpa_ff} :
                      (period_ff == `STM_RST_BYTE ? 17'h10000 : {1'b0, period_ff, `STM_RST_BYTE});
  assign pwm_duty   = ctl.period_duty_swap ?
                      (period_ff == `STM_RST_BYTE ? 17'h10000 : {1'b0, period_ff, `STM_RST_BYTE}) :
                      {1'b0, cmpa_ff};
  assign pwm_act    = {1'b0, cnt_ff} < pwm_duty || pwm_duty >= pwm_period;

  // Compare-mode output and single pulse state
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      out_ff        <= 1'b0;
      pulse_done_ff <= 1'b0;
    end else if (on_rise) begin
      out_ff        <= ctl.output_level_control;
      pulse_done_ff <= 1'b0;
    end else if (ctl.operating_mode_select == STM_MODE_COMPARE && match_a) begin
      case (ctl.output_function_select)
        2'h1:    out_ff <= 1'b0;
        2'h2:    out_ff <= 1'b1;
        2'h3:    out_ff <= ~out_ff;
        default: out_ff <= out_ff;
      endcase
    end else if (ctl.operating_mode_select == STM_MODE_PWM && clr) begin
      pulse_done_ff <= 1'b1;
    end
  end

  // Output function in PWM and single pulse modes
  always_comb begin
    case (ctl.output_function_select)
      2'h0:    pwm_wave = 1'b0;
      2'h1:    pwm_wave = 1'b1;
      2'h2:    pwm_wave = ctl.timer_on & pwm_act;
      default: pwm_wave = ctl.timer_on & pwm_act & ~pulse_done_ff;
    endcase
  end

  // Mode picks the pin source; active level, then invert
  always_comb begin
    case (ctl.operating_mode_select)
      STM_MODE_COMPARE: base_out = out_ff ^ ctl.output_invert;
      STM_MODE_PWM:     base_out = (pwm_wave ~^ ctl.output_level_control) ^ ctl.output_invert;
      default:          base_out = 1'b0;
    endcase
  end

  // Registered pins; timer and capture modes release them
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_TIMER_OUTPUT_FIRST  <= 1'b0;
      O_TIMER_OUTPUT_SECOND <= 1'b0;
      O_TIMER_OUTPUT_OE     <= 1'b0;
    end else begin
      O_TIMER_OUTPUT_FIRST  <= base_out;
      O_TIMER_OUTPUT_SECOND <= base_out ^ I_SECOND_COMPLEMENT;
      O_TIMER_OUTPUT_OE     <= ctl.operating_mode_select != STM_MODE_TIMER && 
                               ctl.operating_mode_select != STM_MODE_CAPTURE;
    end
  end

endmodule
`default_nettype wire

// *** stm_timer_properties.sv ***
// Port checker for the standard timer
`timescale 1ns/1ps
`default_nettype none
module stm_timer_properties #(
  parameter int ADDR_W = 4
) (
  input wire logic              I_CLK,
  input wire logic              I_RST_N,
  input wire logic [ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic              I_AVS_READ,
  input wire logic              I_AVS_WRITE,
  input wire logic [31:0]       O_AVS_READDATA,
  input wire logic              O_AVS_WAITREQUEST,
  input wire logic              I_SECOND_COMPLEMENT,
  input wire logic              O_TIMER_OUTPUT_FIRST,
  input wire logic              O_TIMER_OUTPUT_SECOND,
  input wire logic              O_TIMER_OUTPUT_OE,
  input wire logic              O_COMPARE_A_MATCH_FLAG,
  input wire logic              O_COMPARE_P_MATCH_FLAG
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  logic req;
  logic done;
  logic comp_q1;
  logic comp_q2;
  // Request and completion
  assign req  = I_AVS_READ | I_AVS_WRITE;
  assign done = req & ~O_AVS_WAITREQUEST;
  // Complement input history
  always_ff @(posedge I_CLK) begin
    comp_q1 <= I_SECOND_COMPLEMENT;
    comp_q2 <= comp_q1;
  end
  wait_first_a : assert property (req && !$past(req) |-> O_AVS_WAITREQUEST)
    else $error("Request got no wait cycle");
  wait_once_a : assert property (req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
    else $error("Wait lasted over one cycle");
  upper_zero_a : assert property (done && I_AVS_READ |-> O_AVS_READDATA[31:8] == 24'h0)
    else $error("Read data upper bits set");
  unmapped_zero_a : assert property (done && I_AVS_READ && I_AVS_ADDRESS > 6 |-> O_AVS_READDATA == 0)
    else $error("Unmapped read not zero");
  ctrl_spare_a : assert property (done && I_AVS_READ && I_AVS_ADDRESS == 0 |-> O_AVS_READDATA[2:0] == 3'h0)
    else $error("Control spare bits set");
  a_pulse_a : assert property (O_COMPARE_A_MATCH_FLAG |=> !O_COMPARE_A_MATCH_FLAG)
    else $error("A match pulse too long");
  p_pulse_a : assert property (O_COMPARE_P_MATCH_FLAG |=> !O_COMPARE_P_MATCH_FLAG)
    else $error("P match pulse too long");
  out_pair_a : assert property (comp_q1 == I_SECOND_COMPLEMENT && comp_q2 == comp_q1 && O_TIMER_OUTPUT_OE
    && $past(O_TIMER_OUTPUT_OE) |-> O_TIMER_OUTPUT_SECOND == (O_TIMER_OUTPUT_FIRST ^ I_SECOND_COMPLEMENT))
    else $error("Second output wrong");
  reset_quiet_a : assert property (disable iff (1'b0) !I_RST_N |=> !O_TIMER_OUTPUT_OE && !O_COMPARE_A_MATCH_FLAG
    && !O_COMPARE_P_MATCH_FLAG && !O_TIMER_OUTPUT_FIRST)
    else $error("Output active in reset");
  a_seen_c : cover property (O_COMPARE_A_MATCH_FLAG);
  p_seen_c : cover property (O_COMPARE_P_MATCH_FLAG);
  read_seen_c : cover property (done && I_AVS_READ && I_AVS_ADDRESS == 3);
endmodule
`default_nettype wire

// *** stm_timer_test.sv ***
// Self-checking bench for the standard timer
`timescale 1ns/1ps
`default_nettype none
module test_stm_timer;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic        comp = 1'b0;
  logic        ext = 1'b0;
  logic        cap = 1'b0;
  logic        hclk = 1'b0;
  logic        tb = 1'b0;
  logic [31:0] rdata;
  logic        waitreq, out1, out2, oe, fa, fp;
  logic [31:0] lfsr = 32'ha914;
  int          p_seen = 0;
  int          a_seen = 0;
  int          num_errors = 0;
  int          n_compared = 0;
  // Clock and match pulse counters
  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (fp === 1'b1) p_seen <= p_seen + 1;
    if (fa === 1'b1) a_seen <= a_seen + 1;
  end
  stm_timer u_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
    .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
    .I_EXTERNAL_COUNT_INPUT(ext), .I_CAPTURE_INPUT(cap), .I_INTERNAL_HIGH_CLOCK_TICK(hclk),
    .I_TIME_BASE_CLOCK_TICK(tb), .I_SECOND_COMPLEMENT(comp), .O_TIMER_OUTPUT_FIRST(out1),
    .O_TIMER_OUTPUT_SECOND(out2), .O_TIMER_OUTPUT_OE(oe), .O_COMPARE_A_MATCH_FLAG(fa),
    .O_COMPARE_P_MATCH_FLAG(fp));
  // Random source and expectations
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int exp_gap(input logic [2:0] cks, input int n);
    return (cks == 3'b000) ? 4 * n : n;
  endfunction
  function automatic logic exp_lvl(input logic lv, input logic iv);
    return lv ^ iv;
  endfunction
  function automatic int exp_cap(input logic [1:0] f, input int m);
    return (f == 2'h3) ? 0 : (f == 2'h2) ? 2 * m : m;
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("Compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // One bus transfer, held until waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    int k;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (waitreq !== 1'b0 && k < 50);
    q = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    if (k >= 50) begin
      chk("waitrequest", 1, 0);
      end_sim();
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_cnt(output logic [15:0] v);
    logic [7:0] h;
    logic [7:0] l;
    bus(1'b0, 4'h3, 8'h00, h);
    bus(1'b0, 4'h2, 8'h00, l);
    v = {h, l};
  endtask
  // Waits for m match pulses, returns the last gap
  task automatic pulses(input logic sel, input int m, output int n);
    for (int i = 0; i < m; i++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while ((sel ? fp : fa) !== 1'b1 && n < 70000);
      if (n >= 70000) begin
        chk("match pulse", 0, 1);
        end_sim();
      end
    end
  endtask
  // Drives m ticks of one pin-fed clock source, reads the count back
  task automatic src_run(input logic [2:0] cks, input int m);
    logic [15:0] v;
    wreg(4'h0, 8'h00);
    wreg(4'h0, {1'b0, cks, 1'b1, 3'b000});
    for (int j = 0; j < m; j++) begin
      if (cks == 3'h2 || cks == 3'h3) begin
        hclk <= 1'b1;
        repeat ((cks == 3'h2) ? 16 : 64) @(posedge clk);
        hclk <= 1'b0;
      end else if (cks == 3'h4) begin
        tb <= 1'b1;
        @(posedge clk);
        tb <= 1'b0;
      end else begin
        ext <= 1'b1;
        repeat (2) @(posedge clk);
        ext <= 1'b0;
      end
      repeat (2) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    rd_cnt(v);
    chk("source count", v, m);
  endtask
  // Main sequence
  initial begin
    logic [7:0] q;
    logic [7:0] wv [7];
    logic [15:0] c1, c2;
    logic [2:0] cks;
    logic o;
    int n, cn;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      bus(1'b0, a[3:0], 8'h00, q);
      chk("reset value", q, 0);
    end
    for (int a = 0; a < 7; a++) begin
      lfsr = next_rand(lfsr);
      wv[a] = lfsr[7:0] & 8'hf7;
      wreg(a[3:0], wv[a]);
    end
    bus(1'b0, 4'h0, 8'h00, q);
    chk("ctrl0", q, wv[0] & 8'hf8);
    bus(1'b0, 4'h1, 8'h00, q);
    chk("ctrl1", q, wv[1]);
    bus(1'b0, 4'h5, 8'h00, q);
    chk("cmpa high", q, wv[5]);
    bus(1'b0, 4'h4, 8'h00, q);
    chk("cmpa low", q, wv[4]);
    bus(1'b0, 4'h6, 8'h00, q);
    chk("period", q, wv[6]);
    rd_cnt(c1);
    chk("counter unwritten", c1, 0);
    $display("registers done");
    for (int s = 0; s < 2; s++) begin
      cks = s ? 3'b001 : 3'b000;
      lfsr = next_rand(lfsr);
      cn = 8 + lfsr[4:0];
      wreg(4'h0, 8'h00);
      wreg(4'h1, 8'h31);
      wreg(4'h4, cn[7:0]);
      wreg(4'h5, 8'h01);
      wreg(4'h6, 8'h01);
      wreg(4'h0, {1'b0, cks, 1'b1, 3'b000});
      p_seen = 0;
      pulses(1'b0, 2, n);
      chk("A gap", n, exp_gap(cks, 256 + cn));
      repeat (2) @(posedge clk);
      o = out1;
      pulses(1'b0, 1, n);
      repeat (2) @(posedge clk);
      chk("toggle", out1, !o);
      chk("P under clear on A", p_seen, 0);
    end
    $display("compare done");
    wreg(4'h0, 8'h00);
    wreg(4'h1, 8'h00);
    wreg(4'h6, 8'h01);
    wreg(4'h0, 8'h18);
    pulses(1'b1, 2, n);
    chk("P gap", n, 256);
    wreg(4'h6, 8'h10);
    wreg(4'h0, 8'h98);
    rd_cnt(c1);
    repeat (5) @(posedge clk);
    rd_cnt(c2);
    chk("pause hold", c2, c1);
    wreg(4'h0, 8'h18);
    rd_cnt(c2);
    chk("resume", (c2 > c1) && (c2 - c1 < 30), 1);
    wreg(4'h0, 8'h10);
    rd_cnt(c1);
    repeat (5) @(posedge clk);
    rd_cnt(c2);
    chk("off hold", c2, c1);
    wreg(4'h0, 8'h18);
    rd_cnt(c2);
    chk("on clears", c2 < 16, 1);
    $display("counter done");
    for (int i = 0; i < 4; i++) begin
      wreg(4'h0, 8'h00);
      wreg(4'h1, {4'h0, i[1], i[0], 2'b00});
      wreg(4'h0, 8'h18);
      lfsr = next_rand(lfsr);
      comp <= lfsr[0];
      repeat (3) @(posedge clk);
      chk("first level", out1, exp_lvl(i[1], i[0]));
      chk("second level", out2, exp_lvl(i[1], i[0]) ^ lfsr[0]);
      chk("enable", oe, 1);
    end
    wreg(4'h0, 8'h00);
    wreg(4'h1, 8'hc0);
    wreg(4'h0, 8'h18);
    repeat (3) @(posedge clk);
    chk("timer mode enable", oe, 0);
    $display("outputs done");
    wreg(4'h0, 8'h00);
    wreg(4'h1, 8'h00);
    for (int k = 0; k < 5; k++) begin
      lfsr = next_rand(lfsr);
      src_run(k == 0 ? 3'h2 : k == 1 ? 3'h3 : k == 2 ? 3'h4 : k == 3 ? 3'h6 : 3'h7, 1 + lfsr[2:0]);
    end
    $display("sources done");
    lfsr = next_rand(lfsr);
    wreg(4'h0, 8'h00);
    wreg(4'h1, {4'b1010, lfsr[8], 3'b000});
    wreg(4'h4, {1'b0, lfsr[6:0]} + 8'h01);
    wreg(4'h5, 8'h00);
    wreg(4'h6, 8'h01);
    wreg(4'h0, 8'h18);
    repeat (4) @(posedge clk);
    n = 0;
    repeat (256) begin
      @(posedge clk);
      if (out1 === lfsr[8]) n++;
    end
    chk("PWM duty", n, {1'b0, lfsr[6:0]} + 8'h01);
    $display("pwm done");
    lfsr = next_rand(lfsr);
    wreg(4'h0, 8'h00);
    wreg(4'h1, {2'b01, lfsr[1:0], 4'h0});
    wreg(4'h0, 8'he8);
    a_seen = 0;
    repeat (1 + lfsr[4:2]) begin
      cap <= 1'b1;
      repeat (3) @(posedge clk);
      cap <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (6) @(posedge clk);
    chk("capture events", a_seen, exp_cap(lfsr[1:0], 1 + lfsr[4:2]));
    $display("capture done");
    end_sim();
  end
endmodule
bind stm_timer stm_timer_properties #(.ADDR_W(ADDR_W)) u_prop (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
  .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
  .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
  .I_SECOND_COMPLEMENT(I_SECOND_COMPLEMENT), .O_TIMER_OUTPUT_FIRST(O_TIMER_OUTPUT_FIRST),
  .O_TIMER_OUTPUT_SECOND(O_TIMER_OUTPUT_SECOND), .O_TIMER_OUTPUT_OE(O_TIMER_OUTPUT_OE),
  .O_COMPARE_A_MATCH_FLAG(O_COMPARE_A_MATCH_FLAG), .O_COMPARE_P_MATCH_FLAG(O_COMPARE_P_MATCH_FLAG));
`default_nettype wire
